// File: rtl/vafe_pins.sv
`timescale 1ns/1ns
// What this block does
// - Phase invert input shifts sampling by half pixel.
// - Fast blank output delayed to match pixels.
// - Reset low at least 1 us fully resets.
// - Crystal clock output, full or halved rate.
// - Address select low answers at 0x98.
// - Address select high answers at 0x9A.
// - Serial data open drain, serial clock input.
// - Pixel clock with complement output.
// - Three 10-bit colour words per pixel clock.
// - Aligned line sync is horizontal only.
// - Buffered line sync passes source unmodified.
// - Frame sync asserted while composite pattern disrupted; follows vsync pin in separate hsync mode.
module vafe_pins
#(
  parameter int PIPE = vafe_pkg::PIPE_STAGES
)
(
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            sample_phase_invert_in_i,
  input  wire logic                            fast_blank_in_i,
  input  wire logic                            hsync_in_i,
  input  wire logic                            sync_on_green_in_i,
  input  wire logic                            vsync_in_i,
  input  wire logic [1:0]                      sync_src_sel_i,
  input  wire logic                            xclk_div2_i,
  input  wire logic [vafe_pkg::PIX_W-1:0]      adc_red_i,
  input  wire logic [vafe_pkg::PIX_W-1:0]      adc_green_i,
  input  wire logic [vafe_pkg::PIX_W-1:0]      adc_blue_i,
  input  wire logic                            serial_address_select_i,
  input  wire logic                            scl_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe_o,
  output logic                                 pixel_clk_o,
  output logic                                 pixel_clk_n_o,
  output logic [vafe_pkg::PIX_W-1:0]           red_o,
  output logic [vafe_pkg::PIX_W-1:0]           green_o,
  output logic [vafe_pkg::PIX_W-1:0]           blue_o,
  output logic                                 fast_blank_out_o,
  output logic                                 aligned_line_sync_out_o,
  output logic                                 buffered_line_sync_out_o,
  output logic                                 buffered_frame_sync_out_o,
  output logic                                 crystal_clock_out_o
);
  import vafe_pkg::*;

  localparam int DW = 3 * PIX_W + 2;

  if (PIPE < 1)
  begin : g_pipe_check
    $error("PIPE must be at least one.");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Order: invert, fast blank, hsync, sog, vsync, addr select, scl, sda.
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_q_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta_reg <= 8'hC0;
      pin_q_reg    <= 8'hC0;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end
    else
    begin
      pin_meta_reg <= {sda_i, scl_i, serial_address_select_i, vsync_in_i,
                       sync_on_green_in_i, hsync_in_i, fast_blank_in_i,
                       sample_phase_invert_in_i};
      pin_q_reg    <= pin_meta_reg;
      scl_d_reg    <= pin_q_reg[6];
      sda_d_reg    <= pin_q_reg[7];
    end
  end

  logic inv_q;
  logic fb_q;
  logic vs_q;
  logic asel_q;
  logic scl_q;
  logic sda_q;
  assign inv_q  = pin_q_reg[0];
  assign fb_q   = pin_q_reg[1];
  assign vs_q   = pin_q_reg[4];
  assign asel_q = pin_q_reg[5];
  assign scl_q  = pin_q_reg[6];
  assign sda_q  = pin_q_reg[7];

  // ----------------------------------------------------------------
  // Pixel clock
  // ----------------------------------------------------------------
  // Flipping the invert input stretches one pixel clock phase by a cycle.
  logic ph_reg;
  logic pclk_reg;
  logic pclk_n_reg;
  logic pclk_next;
  logic pix_tick;

  assign pclk_next = ph_reg ^ inv_q;
  assign pix_tick  = pclk_reg && !pclk_next;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ph_reg     <= 1'b0;
      pclk_reg   <= 1'b0;
      pclk_n_reg <= 1'b1;
    end
    else
    begin
      ph_reg     <= !ph_reg;
      pclk_reg   <= pclk_next;
      pclk_n_reg <= !pclk_next;
    end
  end

  assign pixel_clk_o   = pclk_reg;
  assign pixel_clk_n_o = pclk_n_reg;

  // ----------------------------------------------------------------
  // Sync handling
  // ----------------------------------------------------------------
  logic                   src_q;
  logic                   composite;
  logic [PULSE_CNT_W-1:0] width_reg;
  logic                   disrupt_reg;
  logic                   src_d_reg;
  logic                   hs_buf_reg;
  logic                   vs_buf_reg;
  logic                   hs_pure;

  assign src_q     = (sync_src_sel_i == SYNC_SEP_HSYNC || sync_src_sel_i == SYNC_CSYNC)
                     ? pin_q_reg[2] : pin_q_reg[3];
  assign composite = (sync_src_sel_i != SYNC_SEP_HSYNC);
  assign hs_pure   = src_q && !(composite && disrupt_reg);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      width_reg   <= '0;
      disrupt_reg <= 1'b0;
      src_d_reg   <= 1'b0;
    end
    else
    begin
      src_d_reg <= src_q;
      if (!src_q)
        width_reg <= '0;
      else if (width_reg != PULSE_CNT_W'(LONG_PULSE_CYC))
        width_reg <= width_reg + 1'b1;
      if (src_q && width_reg == PULSE_CNT_W'(LONG_PULSE_CYC - 1))
        disrupt_reg <= 1'b1;
      else if (src_d_reg && !src_q && width_reg != PULSE_CNT_W'(LONG_PULSE_CYC))
        disrupt_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      hs_buf_reg <= 1'b0;
      vs_buf_reg <= 1'b0;
    end
    else
    begin
      hs_buf_reg <= src_q;
      vs_buf_reg <= composite ? disrupt_reg : vs_q;
    end
  end

  assign buffered_line_sync_out_o  = hs_buf_reg;
  assign buffered_frame_sync_out_o = vs_buf_reg;

  // ----------------------------------------------------------------
  // Pixel pipeline
  // ----------------------------------------------------------------
  // Words, fast blank and line sync share one chain so they never drift.
  logic [DW-1:0] pipe_out;

  vafe_delay #(
    .WIDTH (DW),
    .DEPTH (PIPE)
  ) u_pipe (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .adv_i   (pix_tick),
    .din_i   ({adc_red_i, adc_green_i, adc_blue_i, fb_q, hs_pure}),
    .dout_o  (pipe_out)
  );

  assign red_o                   = pipe_out[DW-1 -: PIX_W];
  assign green_o                 = pipe_out[2*PIX_W+1 -: PIX_W];
  assign blue_o                  = pipe_out[PIX_W+1 -: PIX_W];
  assign fast_blank_out_o        = pipe_out[1];
  assign aligned_line_sync_out_o = pipe_out[0];

  // ----------------------------------------------------------------
  // Crystal clock output
  // ----------------------------------------------------------------
  logic [1:0] xdiv_reg;
  logic       xclk_reg;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      xdiv_reg <= 2'h0;
      xclk_reg <= 1'b0;
    end
    else
    begin
      xdiv_reg <= xdiv_reg + 2'h1;
      xclk_reg <= xclk_div2_i ? xdiv_reg[1] : xdiv_reg[0];
    end
  end

  assign crystal_clock_out_o = xclk_reg;

  // ----------------------------------------------------------------
  // Serial port address recogniser
  // ----------------------------------------------------------------
  // Only the address phase is served here; the register map lives elsewhere.
  vafe_ser_state_e state_reg;
  logic [7:0]      shift_reg;
  logic [3:0]      bits_reg;
  logic            oe_reg;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_det;
  logic            stop_det;
  logic [6:0]      own_addr;

  assign scl_rise  = scl_q && !scl_d_reg;
  assign scl_fall  = !scl_q && scl_d_reg;
  assign start_det = scl_q && scl_d_reg && sda_d_reg && !sda_q;
  assign stop_det  = scl_q && scl_d_reg && !sda_d_reg && sda_q;
  assign own_addr  = asel_q ? DEV_ADDR_HIGH : DEV_ADDR_LOW;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= SER_IDLE;
      shift_reg <= 8'h00;
      bits_reg  <= 4'h0;
      oe_reg    <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg <= SER_IDLE;
      oe_reg    <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= SER_ADDR;
      bits_reg  <= 4'h0;
      oe_reg    <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        SER_IDLE, SER_IGNORE:
        begin
          oe_reg <= 1'b0;
        end
        SER_ADDR:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_q};
            bits_reg  <= bits_reg + 4'h1;
          end
          else if (scl_fall && bits_reg == ADDR_BITS)
          begin
            if (shift_reg[7:1] == own_addr)
            begin
              state_reg <= SER_ACK;
              oe_reg    <= 1'b1;
            end
            else
              state_reg <= SER_IGNORE;
          end
        end
        SER_ACK:
        begin
          if (scl_fall)
          begin
            state_reg <= SER_IGNORE;
            oe_reg    <= 1'b0;
          end
        end
      endcase
    end
  end

  // The line is only ever pulled low, never driven high.
  always_ff @(posedge clk_i)
  begin
    sda_o <= 1'b0;
  end

  assign sda_oe_o = oe_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  pclk_complement_a: assert property (pixel_clk_n_o == !pixel_clk_o)
    else $error("Pixel clock complement mismatch.");
  // Dividers start from rest, so the first edges after reset are skipped.
  pclk_steady_a: assert property
    ($past(rst_n_i) && $stable(inv_q) |=> $changed(pixel_clk_o))
    else $error("Pixel clock stopped without a phase flip.");
  phase_flip_a: assert property ($changed(inv_q) |=> $stable(pixel_clk_o))
    else $error("Phase flip did not stretch the pixel clock.");
  pixel_edge_a: assert property ($changed(red_o) |-> $fell(pixel_clk_o))
    else $error("Pixel word changed off the falling pixel clock.");
  fb_align_a: assert property ($changed(fast_blank_out_o) |-> $fell(pixel_clk_o))
    else $error("Fast blank output not aligned to pixels.");
  hs_align_a: assert property
    ($changed(aligned_line_sync_out_o) |-> $fell(pixel_clk_o))
    else $error("Aligned line sync not aligned to pixels.");
  // Eight cycles hold at least two pixel ticks, which flushes the default depth.
  pure_hsync_a: assert property
    ((composite && disrupt_reg) [*8] |-> !aligned_line_sync_out_o)
    else $error("Vertical content leaked into aligned line sync.");
  frame_sync_a: assert property
    (composite && src_q && width_reg == PULSE_CNT_W'(LONG_PULSE_CYC - 1)
     ##1 composite |=> buffered_frame_sync_out_o)
    else $error("Frame sync missed a disrupted pattern.");
  buf_line_a: assert property (##1 buffered_line_sync_out_o == $past(src_q))
    else $error("Buffered line sync is not the raw source.");
  xclk_full_a: assert property
    ($past(rst_n_i) && !xclk_div2_i ##1 !xclk_div2_i |=> $changed(crystal_clock_out_o))
    else $error("Crystal clock output not at full rate.");
  addr_low_a: assert property
    (state_reg == SER_ACK && !asel_q |-> shift_reg[7:1] == DEV_ADDR_LOW)
    else $error("Acknowledged a wrong low address.");
  addr_high_a: assert property
    (state_reg == SER_ACK && asel_q |-> shift_reg[7:1] == DEV_ADDR_HIGH)
    else $error("Acknowledged a wrong high address.");
  open_drain_a: assert property (sda_oe_o |-> !sda_o)
    else $error("Serial data driven high.");

  phase_flip_c: cover property ($changed(inv_q));
  ack_seen_c:   cover property (state_reg == SER_ACK);
  frame_c:      cover property (composite && $rose(buffered_frame_sync_out_o));

endmodule // vafe_pins

// File: rtl/vafe_pkg.sv
package vafe_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_MIN_NS  = 1000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // A sync pulse at least this long belongs to the vertical interval.
  localparam int LONG_PULSE_NS  = 8000;
  localparam int LONG_PULSE_CYC = (LONG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W    = 9;

  // ----------------------------------------------------------------
  // Pixel path
  // ----------------------------------------------------------------
  localparam int PIX_W       = 10;
  localparam int PIPE_STAGES = 2;

  // ----------------------------------------------------------------
  // Serial control port address
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_LOW  = 7'h4C;
  localparam logic [6:0] DEV_ADDR_HIGH = 7'h4D;
  localparam logic [3:0] ADDR_BITS     = 4'h8;

  typedef enum logic [1:0]
  {
    SYNC_SEP_HSYNC = 2'b00,
    SYNC_SOG       = 2'b01,
    SYNC_CSYNC     = 2'b10
  } vafe_sync_src_e;

  typedef enum logic [1:0]
  {
    SER_IDLE   = 2'b00,
    SER_ADDR   = 2'b01,
    SER_ACK    = 2'b10,
    SER_IGNORE = 2'b11
  } vafe_ser_state_e;

endpackage

// File: rtl/vafe_delay.sv
`timescale 1ns/1ns
module vafe_delay
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             adv_i,
  input  wire logic [WIDTH-1:0] din_i,
  output logic      [WIDTH-1:0] dout_o
);

  logic [WIDTH-1:0] stage_reg [DEPTH];

  if (DEPTH < 1 || WIDTH < 1)
  begin : g_size_check
    $error("vafe_delay needs positive width and depth.");
  end

  // ----------------------------------------------------------------
  // Shift chain
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_stage
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
          stage_reg[g] <= '0;
        else if (adv_i)
          stage_reg[g] <= (g == 0) ? din_i : stage_reg[(g == 0) ? 0 : g - 1];
      end
    end
  endgenerate

  assign dout_o = stage_reg[DEPTH-1];

endmodule // vafe_delay

// File: dv/vafe_sink.sv
`timescale 1ns/1ns
module vafe_sink
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       pclk_i,
  input  wire logic                       pclk_n_i,
  input  wire logic [vafe_pkg::PIX_W-1:0] red_i,
  input  wire logic [vafe_pkg::PIX_W-1:0] green_i,
  input  wire logic [vafe_pkg::PIX_W-1:0] blue_i,
  input  wire logic                       fb_i,
  output logic      [30:0]                word_o,
  output logic      [15:0]                comp_err_o
);
  import vafe_pkg::*;

  logic pclk_reg;

  always_ff @(posedge clk_i)
  begin
    pclk_reg <= pclk_i;
  end

  // Words are taken on the rising pixel clock, half a period after they change.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      word_o <= '0;
    else if (pclk_i && !pclk_reg)
      word_o <= {fb_i, red_i, green_i, blue_i};
  end

  // A receiver on differential clock inputs sees a glitch if the pair ever agrees.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      comp_err_o <= '0;
    else if (pclk_n_i !== ~pclk_i)
      comp_err_o <= comp_err_o + 16'h1;
  end
endmodule // vafe_sink

// File: dv/tb.sv
`timescale 1ns/1ns
module tb;
  import vafe_pkg::*;

  typedef struct packed
  {
    logic [PIX_W-1:0] r, g, b;
    logic fb;
    logic [1:0] sel;
    logic hs, sog, vs, ls, fs;
  } vafe_row_s;

  logic             clk_i, rst_n_i = 0, inv = 0, fb = 0, hs = 0, sog = 0, vs = 0;
  logic             div2 = 0, asel = 0, scl = 1, sda_m = 1;
  logic [1:0]       sel = 0;
  logic [PIX_W-1:0] r = 0, g = 0, b = 0, ro, go, bo;
  logic             sda_o, sda_oe, pclk, pclk_n, fbo, als, bls, bfs, xclk;
  logic [30:0]      word;
  logic [15:0]      cerr;
  int               fails = 0, checks = 0, n;
  wire              sda_w = sda_oe ? 1'b0 : sda_m;

  vafe_row_s rows [6] = '{
    '{10'h3FF, 10'h000, 10'h155, 1'b1, 2'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1},
    '{10'h000, 10'h3FF, 10'h2AA, 1'b0, 2'h1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0},
    '{10'h200, 10'h1FF, 10'h001, 1'b1, 2'h2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
    '{10'h2AA, 10'h155, 10'h3FE, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
    '{10'h001, 10'h200, 10'h3FF, 1'b1, 2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
    '{10'h123, 10'h0AB, 10'h3C0, 1'b0, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0}};

  vafe_pins #(.PIPE(PIPE_STAGES)) vafe_pins_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sample_phase_invert_in_i(inv),
    .fast_blank_in_i(fb), .hsync_in_i(hs), .sync_on_green_in_i(sog), .vsync_in_i(vs),
    .sync_src_sel_i(sel), .xclk_div2_i(div2), .adc_red_i(r), .adc_green_i(g),
    .adc_blue_i(b), .serial_address_select_i(asel), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .pixel_clk_o(pclk), .pixel_clk_n_o(pclk_n),
    .red_o(ro), .green_o(go), .blue_o(bo), .fast_blank_out_o(fbo),
    .aligned_line_sync_out_o(als), .buffered_line_sync_out_o(bls),
    .buffered_frame_sync_out_o(bfs), .crystal_clock_out_o(xclk));

  vafe_sink vafe_sink_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pclk_i(pclk), .pclk_n_i(pclk_n), .red_i(ro),
    .green_i(go), .blue_i(bo), .fb_i(fbo), .word_o(word), .comp_err_o(cerr));

  initial
  begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Holds reset for 20 clock cycles, one microsecond; the start-up hold ends at 975 ns, half a cycle short.
  task automatic do_reset;
    rst_n_i <= 1'b0;
    cyc(20);
    check("reset outputs", {ro, go, bo, fbo, als, bls, bfs, xclk, pclk, pclk_n, sda_oe}, 40'h2);
    rst_n_i <= 1'b1;
  endtask

  task automatic count_tog(input bit of_xclk, input int k, output int t);
    logic prev;
    t = 0;
    repeat (k)
    begin
      prev = of_xclk ? xclk : pclk;
      cyc(1);
      if ((of_xclk ? xclk : pclk) !== prev)
        t++;
    end
  endtask

  task automatic sbit(input logic v);
    sda_m <= v;
    cyc(4);
    scl <= 1'b1;
    cyc(8);
    scl <= 1'b0;
    cyc(4);
  endtask

  task automatic addr_byte(input logic [7:0] a);
    logic ack;
    cyc(8);
    // The caller sets the select pin in this time step, so it is read once settled.
    ack = ({a[7:1], 1'b0} == (asel ? 8'h9A : 8'h98));
    sda_m <= 1'b0;
    cyc(8);
    scl <= 1'b0;
    cyc(4);
    for (int i = 7; i >= 0; i--)
      sbit(a[i]);
    sda_m <= 1'b1;
    cyc(4);
    check("ack", sda_oe, ack);
    check("sda wire", sda_w, !ack);
    check("sda data", sda_o, 0);
    scl <= 1'b1;
    cyc(8);
    scl <= 1'b0;
    cyc(8);
    check("ack release", sda_oe, 0);
    sda_m <= 1'b0;
    cyc(4);
    scl <= 1'b1;
    cyc(8);
    sda_m <= 1'b1;
  endtask

  initial
  begin
    cyc(8000);
    fails++;
    report_and_stop();
  end

  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      {r, g, b, fb, sel, hs, sog, vs} <= rows[i][37:2];
      cyc(14);
      check("sink word", word, {rows[i].fb, rows[i].r, rows[i].g, rows[i].b});
      check("pixel outs", {fbo, ro, go, bo}, {rows[i].fb, rows[i].r, rows[i].g, rows[i].b});
      check("line sync", bls, rows[i].ls);
      check("aligned sync", als, rows[i].ls);
      check("frame sync", bfs, rows[i].fs);
    end
    // Ending the last short line pulse lets the vertical test start from idle.
    hs <= 1'b0;
    for (int d = 0; d < 2; d++)
    begin
      div2 <= d[0];
      cyc(8);
      count_tog(1'b1, 32, n);
      check("crystal toggles", n, d ? 16 : 32);
    end
    count_tog(1'b0, 40, n);
    check("pixel toggles", n, 40);
    vs  <= 1'b1;
    inv <= 1'b1;
    count_tog(1'b0, 40, n);
    check("inverted toggles", n, 39);
    vs  <= 1'b0;
    sel <= 2'h2;
    hs <= 1'b1;
    cyc(150);
    check("vertical early", bfs, 0);
    cyc(20);
    check("vertical start", bfs, 1);
    check("vertical aligned", als, 0);
    hs <= 1'b0;
    cyc(10);
    check("vertical hold", bfs, 1);
    hs <= 1'b1;
    cyc(20);
    check("short pulse", bls, 1);
    hs <= 1'b0;
    cyc(8);
    check("vertical end", bfs, 0);
    for (int k = 0; k < 6; k++)
    begin
      asel <= k[0];
      addr_byte(k[2] ? 8'h99 : (k[1] ? 8'h9A : 8'h98));
    end
    check("complement errors", cerr, 0);
    do_reset();
    report_and_stop();
  end
endmodule // tb
